// ===== hdl/dio_objects.sv
// Functional notes
// (RULE1) second analog output value is read/write; address subindex reads 0x0008.
// (RULE2) digital output value is read/write; address subindex reads 0x0009.
// (RULE3) status word is read-only, refreshed every 2 ms, unfiltered.
// (RULE4) bit0 running, bit1 zero speed, bit2 reverse rotation.
// (RULE5) bits 3..9: fault reset, speed agree, ready, alarm, fault, op error, power loss.
// (RULE6) bit A network control, B..D digital outputs, E motor 2, F zero-servo end.
// (RULE7) status address subindex reads drive register 0x00FC.
// (RULE8) output frequency read-only 16-bit; address subindex reads 0x0041.
// (RULE9) frequency scaled by unit code: Hz, percent, rpm, user scale.
// (RULE10) output current read-only 16-bit, monitor resolution; address reads 0x00FB.
// (RULE11) all sixteen status bits update together as one word.
`timescale 1ns/10ps
`include "dio_map.svh"
module dio_objects
  import dio_pkg::*;
#(
  parameter int REFRESH_CYCLES = `DIO_REFRESH_TIME_NS / `DIO_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // object access from the fieldbus side
  input wire logic obj_valid,
  input wire dio_req_s obj_req,
  output logic obj_ack,
  output logic obj_err,
  output logic [15:0] obj_rdata,
  // drive monitor inputs
  input wire dio_stat_s drive_status,
  input wire logic [15:0] frequency_monitor_param,
  input wire logic [15:0] current_monitor_param,
  // drive settings
  input wire logic [1:0] frequency_unit_select,
  input wire logic [15:0] maximum_frequency_param,
  input wire logic [7:0] motor_poles,
  input wire logic [15:0] user_scale,
  // drive outputs
  output logic [15:0] second_analog_out,
  output logic [15:0] digital_output_value,
  output logic refresh_tick
);
  localparam int CW = $clog2(REFRESH_CYCLES + 1);

  logic [CW-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  logic [15:0] status_r, status_nxt;
  logic [15:0] curr_r, curr_nxt;
  logic [15:0] freq_r, freq_nxt;
  logic [15:0] aout_r, aout_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic sc_done;
  logic [15:0] sc_result;
  logic idx_known;

  ////////////////////////////////////////////////////////////////////////
  // refresh divider
  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + CW'(1);
    if (tick_cnt_r == CW'(REFRESH_CYCLES - 1)) begin
      tick_cnt_nxt = '0;
      tick_nxt = 1'b1; // see (RULE3)
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // monitor snapshots
  dio_scale u_scale (
    .clk(clk),
    .resetn(resetn),
    .start(tick_r),
    .unit_sel(frequency_unit_select),
    .raw(frequency_monitor_param),
    .max_freq(maximum_frequency_param),
    .poles(motor_poles),
    .user_scale(user_scale),
    .done(sc_done),
    .result(sc_result)
  );

  always_comb begin
    status_nxt = status_r;
    curr_nxt = curr_r;
    freq_nxt = freq_r;
    if (tick_r) begin
      // whole word captured in one edge, bits straight through
      status_nxt = drive_status; // see (RULE3) see (RULE4) see (RULE5) see (RULE6) see (RULE11)
      curr_nxt = current_monitor_param; // see (RULE10)
    end
    if (sc_done) begin
      freq_nxt = sc_result; // see (RULE8) see (RULE9)
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_r <= 16'h0000;
      curr_r <= 16'h0000;
      freq_r <= 16'h0000;
    end else begin
      status_r <= status_nxt;
      curr_r <= curr_nxt;
      freq_r <= freq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // index decode
  always_comb begin
    idx_known = 1'b0;
    case (obj_req.index)
      `DIO_IDX_AOUT2: begin
        idx_known = 1'b1; // see (RULE1)
      end
      `DIO_IDX_DOUT: begin
        idx_known = 1'b1; // see (RULE2)
      end
      `DIO_IDX_STATUS: begin
        idx_known = 1'b1; // see (RULE3)
      end
      `DIO_IDX_FREQ: begin
        idx_known = 1'b1; // see (RULE8)
      end
      `DIO_IDX_CURR: begin
        idx_known = 1'b1; // see (RULE10)
      end
      default: begin
        idx_known = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // object access
  always_comb begin
    aout_nxt = aout_r;
    dout_nxt = dout_r;
    ack_nxt = obj_valid;
    err_nxt = 1'b0;
    rdata_nxt = 16'h0000;
    if (obj_valid) begin
      if (obj_req.subidx == `DIO_SUB_COUNT) begin
        rdata_nxt = `DIO_ENTRY_COUNT;
        // entry count only for objects that exist
        err_nxt = obj_req.wr | ~idx_known;
      end else if (obj_req.subidx == `DIO_SUB_VALUE) begin
        case (obj_req.index)
          `DIO_IDX_AOUT2: begin
            rdata_nxt = aout_r;
            if (obj_req.wr) begin
              aout_nxt = obj_req.wdata; // see (RULE1)
            end
          end
          `DIO_IDX_DOUT: begin
            rdata_nxt = dout_r;
            if (obj_req.wr) begin
              dout_nxt = obj_req.wdata; // see (RULE2)
            end
          end
          `DIO_IDX_STATUS: begin
            rdata_nxt = status_r; // see (RULE11)
            err_nxt = obj_req.wr; // see (RULE3)
          end
          `DIO_IDX_FREQ: begin
            rdata_nxt = freq_r;
            err_nxt = obj_req.wr; // see (RULE8)
          end
          `DIO_IDX_CURR: begin
            rdata_nxt = curr_r;
            err_nxt = obj_req.wr; // see (RULE10)
          end
          default: err_nxt = 1'b1;
        endcase
      end else if (obj_req.subidx == `DIO_SUB_ADDR) begin
        // address subindices are read-only
        err_nxt = obj_req.wr;
        case (obj_req.index)
          `DIO_IDX_AOUT2: rdata_nxt = `DIO_REG_AOUT2; // see (RULE1)
          `DIO_IDX_DOUT: rdata_nxt = `DIO_REG_DOUT; // see (RULE2)
          `DIO_IDX_STATUS: rdata_nxt = `DIO_REG_STATUS; // see (RULE7)
          `DIO_IDX_FREQ: rdata_nxt = `DIO_REG_FREQ; // see (RULE8)
          `DIO_IDX_CURR: rdata_nxt = `DIO_REG_CURR; // see (RULE10)
          default: err_nxt = 1'b1;
        endcase
      end else begin
        err_nxt = 1'b1;
      end
      if (err_nxt) begin
        rdata_nxt = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aout_r <= `DIO_AOUT2_RST;
      dout_r <= `DIO_DOUT_RST;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      aout_r <= aout_nxt;
      dout_r <= dout_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from registers
  assign obj_ack = ack_r;
  assign obj_err = err_r;
  assign obj_rdata = rdata_r;
  assign second_analog_out = aout_r;
  assign digital_output_value = dout_r;
  assign refresh_tick = tick_r;
endmodule

// ===== hdl/dio_map.svh
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH
// object indices
`define DIO_IDX_AOUT2 16'h20E0
`define DIO_IDX_DOUT 16'h20F0
`define DIO_IDX_STATUS 16'h2100
`define DIO_IDX_FREQ 16'h2110
`define DIO_IDX_CURR 16'h2120
// subindices
`define DIO_SUB_COUNT 8'h00
`define DIO_SUB_VALUE 8'h01
`define DIO_SUB_ADDR 8'h02
`define DIO_ENTRY_COUNT 16'h0002
// linked drive register addresses
`define DIO_REG_AOUT2 16'h0008
`define DIO_REG_DOUT 16'h0009
`define DIO_REG_STATUS 16'h00FC
`define DIO_REG_FREQ 16'h0041
`define DIO_REG_CURR 16'h00FB
// reset values
`define DIO_AOUT2_RST 16'h0000
`define DIO_DOUT_RST 16'h0000
// frequency unit codes
`define DIO_UNIT_HZ 2'h0
`define DIO_UNIT_PCT 2'h1
`define DIO_UNIT_RPM 2'h2
`define DIO_UNIT_USER 2'h3
// scaling factors
`define DIO_PCT_FULL 32'h0000_2710
`define DIO_RPM_NUM 32'h0000_0078
`define DIO_RPM_DEN 16'h0064
// timing
`define DIO_CLK_PERIOD_NS 100
`define DIO_REFRESH_TIME_NS 2000000
`endif

// ===== hdl/dio_pkg.sv
package dio_pkg;
  typedef struct packed {
    logic wr;
    logic [15:0] index;
    logic [7:0] subidx;
    logic [15:0] wdata;
  } dio_req_s;
  typedef struct packed {
    logic zero_servo_end;
    logic motor2_sel;
    logic dout3_on;
    logic dout2_on;
    logic dout1_on;
    logic network_control_flag;
    logic power_loss;
    logic op_error;
    logic fault;
    logic alarm;
    logic ready;
    logic speed_agree;
    logic fault_reset_in;
    logic reverse;
    logic zero_speed;
    logic running;
  } dio_stat_s;
  typedef enum logic [0:0] {
    DIO_SC_IDLE,
    DIO_SC_DIV
  } dio_sc_e;
endpackage

// ===== hdl/dio_scale.sv
`timescale 1ns/10ps
`include "dio_map.svh"
module dio_scale
  import dio_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // request
  input wire logic start,
  input wire logic [1:0] unit_sel,
  input wire logic [15:0] raw,
  input wire logic [15:0] max_freq,
  input wire logic [7:0] poles,
  input wire logic [15:0] user_scale,
  // result
  output logic done,
  output logic [15:0] result
);
  dio_sc_e state_r, state_nxt;
  logic [31:0] quo_r, quo_nxt;
  logic [32:0] rem_r, rem_nxt;
  logic [15:0] den_r, den_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;
  logic [15:0] res_r, res_nxt;
  logic [32:0] trial;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    quo_nxt = quo_r;
    rem_nxt = rem_r;
    den_nxt = den_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    res_nxt = res_r;
    trial = {rem_r[31:0], quo_r[31]} - {17'h0_0000, den_r};
    case (state_r)
      DIO_SC_IDLE: begin
        if (start) begin
          quo_nxt = 32'h0000_0000;
          rem_nxt = 33'h0_0000_0000;
          cnt_nxt = 6'h20;
          case (unit_sel) // see (RULE9)
            `DIO_UNIT_PCT: begin
              quo_nxt = 32'({16'h0000, raw} * `DIO_PCT_FULL);
              den_nxt = max_freq;
            end
            `DIO_UNIT_RPM: begin
              quo_nxt = 32'({16'h0000, raw} * `DIO_RPM_NUM);
              den_nxt = 16'({8'h00, poles} * `DIO_RPM_DEN);
            end
            `DIO_UNIT_USER: begin
              quo_nxt = 32'({16'h0000, raw} * {16'h0000, user_scale});
              den_nxt = max_freq;
            end
            default: begin
              den_nxt = 16'h0000;
            end
          endcase
          if (unit_sel == `DIO_UNIT_HZ) begin
            res_nxt = raw;
            done_nxt = 1'b1;
          end else if (den_nxt == 16'h0000) begin
            res_nxt = 16'hFFFF;
            done_nxt = 1'b1;
          end else begin
            state_nxt = DIO_SC_DIV;
          end
        end
      end
      DIO_SC_DIV: begin
        // one restoring step per cycle
        if (!trial[32]) begin
          rem_nxt = trial;
          quo_nxt = {quo_r[30:0], 1'b1};
        end else begin
          rem_nxt = {rem_r[31:0], quo_r[31]};
          quo_nxt = {quo_r[30:0], 1'b0};
        end
        cnt_nxt = cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          res_nxt = (quo_nxt[31:16] != 16'h0000) ? 16'hFFFF : quo_nxt[15:0];
          done_nxt = 1'b1;
          state_nxt = DIO_SC_IDLE;
        end
      end
      default: state_nxt = DIO_SC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= DIO_SC_IDLE;
      quo_r <= 32'h0000_0000;
      rem_r <= 33'h0_0000_0000;
      den_r <= 16'h0000;
      cnt_r <= 6'h00;
      done_r <= 1'b0;
      res_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      quo_r <= quo_nxt;
      rem_r <= rem_nxt;
      den_r <= den_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      res_r <= res_nxt;
    end
  end

  assign done = done_r;
  assign result = res_r;
endmodule

// ===== testbench/dio_objects_properties.sv
`timescale 1ns/10ps
`include "dio_map.svh"
module dio_objects_properties
  import dio_pkg::*;
#(
  parameter int REFRESH_CYCLES = `DIO_REFRESH_TIME_NS / `DIO_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // object port
  input wire logic obj_valid,
  input wire dio_req_s obj_req,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic [15:0] obj_rdata,
  // outputs
  input wire logic [15:0] second_analog_out,
  input wire logic [15:0] digital_output_value,
  input wire logic refresh_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [15:0] cnt_r;
  logic seen_r;
  // cycles since last tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      cnt_r <= refresh_tick ? 16'h0001 : cnt_r + 16'h0001;
      seen_r <= seen_r | refresh_tick;
    end
  end
  ////////////////////////////////////////////////////////////////
  AST_AOUT_WR: assert property (obj_valid && obj_req.wr && obj_req.index == `DIO_IDX_AOUT2 && obj_req.subidx == 8'h01 |=>
    !obj_err && second_analog_out == $past(obj_req.wdata)) else $error("analog out write lost");
  AST_DOUT_WR: assert property (obj_valid && obj_req.wr && obj_req.index == `DIO_IDX_DOUT && obj_req.subidx == 8'h01 |=>
    !obj_err && digital_output_value == $past(obj_req.wdata)) else $error("digital out write lost");
  AST_STAT_RO: assert property (obj_valid && obj_req.wr && obj_req.index == `DIO_IDX_STATUS |=> obj_err)
    else $error("status write accepted");
  AST_ADDR_STAT: assert property (obj_valid && !obj_req.wr && obj_req.index == 16'h2100 && obj_req.subidx == 8'h02
    |=> obj_rdata == 16'h00FC) else $error("status address wrong");
  AST_ADDR_FREQ: assert property (obj_valid && !obj_req.wr && obj_req.index == 16'h2110 && obj_req.subidx == 8'h02
    |=> obj_rdata == 16'h0041) else $error("frequency address wrong");
  AST_ADDR_CURR: assert property (obj_valid && !obj_req.wr && obj_req.index == 16'h2120 && obj_req.subidx == 8'h02
    |=> obj_rdata == 16'h00FB) else $error("current address wrong");
  AST_TICK_PERIOD: assert property (refresh_tick && seen_r |-> cnt_r == REFRESH_CYCLES)
    else $error("refresh period wrong");
  AST_ACK_ONCE: assert property (obj_valid ##1 !obj_valid |-> obj_ack ##1 !obj_ack)
    else $error("answer strobe wrong");
endmodule
bind dio_objects dio_objects_properties #(.REFRESH_CYCLES(REFRESH_CYCLES)) i_dio_objects_properties (.clk(clk),
  .resetn(resetn), .obj_valid(obj_valid), .obj_req(obj_req), .obj_ack(obj_ack), .obj_err(obj_err),
  .obj_rdata(obj_rdata), .second_analog_out(second_analog_out), .digital_output_value(digital_output_value),
  .refresh_tick(refresh_tick));

// ===== testbench/dio_master_model.sv
`timescale 1ns/10ps
module dio_master_model
  import dio_pkg::*;
(
  // clock
  input wire logic clk,
  // bench side
  input wire logic go,
  input wire dio_req_s req_in,
  output logic done,
  output logic err,
  output logic [15:0] rdata,
  // object port
  output logic obj_valid,
  output dio_req_s obj_req,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic [15:0] obj_rdata
);
  // one request per go cycle, answer latched
  always_ff @(posedge clk) begin
    obj_valid <= go;
    obj_req <= go ? req_in : ~obj_req;
    done <= obj_ack;
    err <= obj_err;
    rdata <= obj_rdata;
  end
endmodule

// ===== testbench/drive_io_status_objects_tb_top.sv
`timescale 1ns/10ps
module drive_io_status_objects_tb_top
  import dio_pkg::*;
;
  logic clk = 0, resetn = 0, go = 0, done, err, obj_valid, obj_ack, obj_err, refresh_tick;
  dio_req_s req_in = '0, obj_req;
  dio_stat_s st = '0;
  logic [15:0] rdata, obj_rdata, fr = 0, cu = 0, mx = 1, us = 0, ao, dout, rd, wv, idx[5], ad[5];
  logic [1:0] un = 0;
  logic [7:0] po = 0;
  int fail_count = 0, n_tests = 0, cyc = 0;
  always #50 clk = ~clk;
  dio_master_model i_dio_master_model (.clk(clk), .go(go), .req_in(req_in), .done(done), .err(err), .rdata(rdata),
    .obj_valid(obj_valid), .obj_req(obj_req), .obj_ack(obj_ack), .obj_err(obj_err), .obj_rdata(obj_rdata));
  dio_objects #(.REFRESH_CYCLES(64)) i_dio_objects (.clk(clk), .resetn(resetn), .obj_valid(obj_valid),
    .obj_req(obj_req), .obj_ack(obj_ack), .obj_err(obj_err), .obj_rdata(obj_rdata), .drive_status(st),
    .frequency_monitor_param(fr), .current_monitor_param(cu), .frequency_unit_select(un),
    .maximum_frequency_param(mx), .motor_poles(po), .user_scale(us), .second_analog_out(ao),
    .digital_output_value(dout), .refresh_tick(refresh_tick));
  ////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("counts: fail_count=%0d n_tests=%0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [15:0] d);
    int n;
    @(posedge clk) go <= 1;
    req_in <= '{w, i, s, d};
    @(posedge clk) go <= 0;
    n = 0;
    do begin
      @(posedge clk) #1 n++;
    end while (done !== 1'b1 && n < 20);
    if (done !== 1'b1) chk({15'h0000, done}, 16'h0001);
    rd = rdata;
  endtask
  function logic [15:0] fexp(input logic [1:0] u, input logic [15:0] r, m, s, input logic [7:0] p);
    logic [47:0] nm, dn;
    nm = u == 1 ? 48'(r) * 10000 : u == 2 ? 48'(r) * 120 : 48'(r) * s;
    dn = u == 2 ? 48'(p) * 100 : 48'(m);
    if (u == 0) return r;
    if (dn == 0 || nm / dn > 48'hFFFF) return 16'hFFFF;
    return 16'(nm / dn);
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    idx = '{16'h20E0, 16'h20F0, 16'h2100, 16'h2110, 16'h2120};
    ad = '{16'h0008, 16'h0009, 16'h00FC, 16'h0041, 16'h00FB};
    void'($urandom(32'h95d19aff));
    repeat (3) @(posedge clk);
    resetn <= 1;
    for (int i = 0; i < 5; i++) begin
      acc(0, idx[i], 8'h00, 0);
      chk(rd, 16'h0002);
      acc(0, idx[i], 8'h02, 0);
      chk(rd, ad[i]);
      acc(1, idx[i], 8'h01, 16'h5A5A);
      chk(err, i > 1);
    end
    for (int i = 0; i < 2; i++) begin
      wv = 16'(i + $urandom);
      acc(1, idx[i], 8'h01, wv);
      chk(rd, 16'h5A5A);
      chk(i ? dout : ao, wv);
      acc(1, idx[i], 8'h02, 16'hFFFF);
      chk(err, 1);
      acc(0, idx[i], 8'h01, 0);
      chk(rd, wv);
      chk(i ? dout : ao, wv);
    end
    acc(0, 16'h2130, 8'h01, 0);
    chk(err, 1);
    acc(0, 16'h2130, 8'h00, 0);
    chk(err, 1);
    chk(rd, 16'h0000);
    acc(0, 16'h2100, 8'h03, 0);
    chk(err, 1);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk) st <= i < 16 ? 16'h1 << i : 16'($urandom);
      fr <= 16'($urandom);
      cu <= 16'($urandom);
      un <= 2'(i);
      mx <= 16'(i == 7 ? 0 : $urandom);
      po <= 8'($urandom);
      us <= 16'($urandom);
      do @(posedge clk) #1; while (refresh_tick !== 1'b1);
      @(posedge clk) st <= ~st;
      cu <= ~cu;
      repeat (36) @(posedge clk);
      acc(0, 16'h2100, 8'h01, 0);
      chk(rd, ~st);
      acc(0, 16'h2110, 8'h01, 0);
      chk(rd, fexp(un, fr, mx, us, po));
      acc(0, 16'h2120, 8'h01, 0);
      chk(rd, ~cu);
    end
    give_verdict;
  end
endmodule
